//--- logic/sotd_map.svh
// Byte, field and reset constants of the safe output telegram decoder
`ifndef SOTD_MAP_SVH
`define SOTD_MAP_SVH
`define SOTD_BYTE_SEL_LO 3'h0
`define SOTD_BYTE_SEL_HI 3'h2
`define SOTD_BYTE_RES_A 3'h4
`define SOTD_BYTE_RES_B 3'h5
`define SOTD_SEL_MSB 4
`define SOTD_SEL_LSB 0
`define SOTD_BIT_RES_WARN 0
`define SOTD_BIT_RES_PROT 1
`define SOTD_SEL_RESET 5'h00
`define SOTD_MODE_TWO 2'h0
`define SOTD_MODE_FOUR 2'h1
`define SOTD_MODE_MULTI 2'h2
`endif

//--- logic/sotd_pkg.sv
// Types of the safe output telegram decoder
package sotd_pkg;
  typedef enum logic [1:0] {
    SOTD_TWO_FUNC = 2'b00,
    SOTD_TWO_FOUR = 2'b01,
    SOTD_TWO_MULTI = 2'b10,
    SOTD_BAD_MODE = 2'b11
  } sotd_mode_type;
  typedef struct packed {
    logic warn_restart;
    logic prot_restart;
  } sotd_restart_type;
  typedef struct packed {
    logic [4:0] sel_a;
    logic [4:0] sel_b;
    logic [4:0] sel_joint_lo;
    logic [4:0] sel_joint_hi;
    logic [4:0] bank_sel;
    logic [4:0] field_sel;
    sotd_restart_type res_a;
    sotd_restart_type res_b;
  } sotd_out_type;
endpackage

//--- logic/sotd_byte_store.sv
// Six-byte telegram store with registered read-out
`timescale 1ns/1ps
module sotd_byte_store import sotd_pkg::*; #(
  parameter int DEPTH = 6
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic wr_en,
  input wire logic [7:0] wr_data [DEPTH],
  output logic [7:0] rd_data [DEPTH]
);
  logic [7:0] mem_reg [DEPTH];
  logic [7:0] mem_next [DEPTH];

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      mem_next[i] = wr_en ? wr_data[i] : mem_reg[i];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= 8'h00;
      end
    end else if (ce) begin
      mem_reg <= mem_next;
    end
  end

  assign rd_data = mem_reg;
endmodule // sotd_byte_store

//--- logic/sotd_decoder.sv
// Safe output telegram decoder for the two-function modes
// Functional notes
// [RULE1] Two-function: byte 0 bits 0-4 select A
// [RULE2] Two-function: byte 2 bits 0-4 select B
// [RULE3] Byte 4 bits 0,1: restart A, active high
// [RULE4] Byte 5 bits 0,1: restart B, active high
// [RULE5] Four-field: byte 0 group one, joint A,B
// [RULE6] Four-field: byte 2 group two, joint A,B
// [RULE7] Multi-config: byte 0 selects shared bank
// [RULE8] Multi-config: byte 2 selects shared field
// [RULE9] Bytes keep module index in telegram
// [RULE10] Reserved bits zero from host, ignored here
`timescale 1ns/1ps
`include "sotd_map.svh"
module sotd_decoder import sotd_pkg::*; (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [1:0] mode,
  input wire logic tel_valid,
  input wire logic [7:0] tel_byte [6],
  output logic [4:0] switch_input_first_to_fifth,
  output logic [4:0] switch_input_sixth_to_tenth,
  output sotd_out_type dec_out,
  output logic mode_err
);
  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  // Release is timed to the clock so no flop leaves reset a cycle before its neighbour
  logic rst_meta_reg;
  logic rst_sync_reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // ------------------------------------------------------------
  // Telegram capture
  // ------------------------------------------------------------
  // Bytes are stored at their module index, no reordering
  logic [7:0] store_data [6];
  logic cap_reg;
  logic cap_next;
  logic [1:0] mode_reg;
  logic [1:0] mode_next;

  sotd_byte_store #(.DEPTH(6)) u_store (
    .clk(clk),
    .rst_n(rst_sync_reg),
    .ce(ce),
    .wr_en(tel_valid),
    .wr_data(tel_byte),
    .rd_data(store_data)
  ); // RULE9

  function automatic logic [4:0] sel_field(input logic [7:0] b);
    // Bits 5-7 are reserved and dropped
    sel_field = b[`SOTD_SEL_MSB:`SOTD_SEL_LSB]; // RULE10
  endfunction

  function automatic sotd_restart_type res_field(input logic [7:0] b);
    res_field.warn_restart = b[`SOTD_BIT_RES_WARN];
    res_field.prot_restart = b[`SOTD_BIT_RES_PROT];
  endfunction

  always_comb begin
    cap_next = tel_valid;
    mode_next = tel_valid ? mode : mode_reg;
  end

  always_ff @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      cap_reg <= 1'b0;
      mode_reg <= 2'h0;
    end else if (ce) begin
      cap_reg <= cap_next;
      mode_reg <= mode_next;
    end
  end

  // ------------------------------------------------------------
  // Mode decode
  // ------------------------------------------------------------
  // Unused selection outputs held at zero so a stale mode never leaks
  sotd_out_type out_reg;
  sotd_out_type out_next;
  logic [4:0] lo_reg;
  logic [4:0] lo_next;
  logic [4:0] hi_reg;
  logic [4:0] hi_next;
  logic err_reg;
  logic err_next;
  logic [4:0] sel_lo;
  logic [4:0] sel_hi;

  always_comb begin
    sel_lo = sel_field(store_data[`SOTD_BYTE_SEL_LO]);
    sel_hi = sel_field(store_data[`SOTD_BYTE_SEL_HI]);
    out_next = out_reg;
    lo_next = lo_reg;
    hi_next = hi_reg;
    err_next = err_reg;
    if (cap_reg) begin
      out_next = '0;
      lo_next = sel_lo;
      hi_next = sel_hi;
      err_next = 1'b0;
      out_next.res_a = res_field(store_data[`SOTD_BYTE_RES_A]); // RULE3
      out_next.res_b = res_field(store_data[`SOTD_BYTE_RES_B]); // RULE4
      case (sotd_mode_type'(mode_reg))
        SOTD_TWO_FUNC: begin
          out_next.sel_a = sel_lo; // RULE1
          out_next.sel_b = sel_hi; // RULE2
        end
        SOTD_TWO_FOUR: begin
          out_next.sel_joint_lo = sel_lo; // RULE5
          out_next.sel_joint_hi = sel_hi; // RULE6
        end
        SOTD_TWO_MULTI: begin
          out_next.bank_sel = sel_lo; // RULE7
          out_next.field_sel = sel_hi; // RULE8
        end
        default: begin
          // Unknown mode: drop all dec_out requests and set mode_err; raw switch inputs still follow bytes 0 and 2
          out_next = '0;
          err_next = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      out_reg <= '0;
      lo_reg <= `SOTD_SEL_RESET;
      hi_reg <= `SOTD_SEL_RESET;
      err_reg <= 1'b0;
    end else if (ce) begin
      out_reg <= out_next;
      lo_reg <= lo_next;
      hi_reg <= hi_next;
      err_reg <= err_next;
    end
  end

  assign dec_out = out_reg;
  assign switch_input_first_to_fifth = lo_reg;
  assign switch_input_sixth_to_tenth = hi_reg;
  assign mode_err = err_reg;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_sync_reg);

  a_two_func_sela: assert property (ce && tel_valid && mode == 2'h0 ##1 ce |=> // RULE1
    dec_out.sel_a == $past(tel_byte[0][4:0], 2)) else $error("sel_a wrong");
  a_two_func_selb: assert property (ce && tel_valid && mode == 2'h0 ##1 ce |=> // RULE2
    dec_out.sel_b == $past(tel_byte[2][4:0], 2)) else $error("sel_b wrong");
  a_restart_a: assert property (ce && tel_valid && mode != 2'h3 ##1 ce |=> // RULE3
    dec_out.res_a.warn_restart == $past(tel_byte[4][0], 2) &&
    dec_out.res_a.prot_restart == $past(tel_byte[4][1], 2)) else $error("restart A wrong");
  a_restart_b: assert property (ce && tel_valid && mode != 2'h3 ##1 ce |=> // RULE4
    dec_out.res_b.warn_restart == $past(tel_byte[5][0], 2) &&
    dec_out.res_b.prot_restart == $past(tel_byte[5][1], 2)) else $error("restart B wrong");
  a_four_lo: assert property (ce && tel_valid && mode == 2'h1 ##1 ce |=> // RULE5
    dec_out.sel_joint_lo == $past(tel_byte[0][4:0], 2) && dec_out.sel_a == 5'h0)
    else $error("group one wrong");
  a_four_hi: assert property (ce && tel_valid && mode == 2'h1 ##1 ce |=> // RULE6
    dec_out.sel_joint_hi == $past(tel_byte[2][4:0], 2)) else $error("group two wrong");
  a_multi_bank: assert property (ce && tel_valid && mode == 2'h2 ##1 ce |=> // RULE7
    dec_out.bank_sel == $past(tel_byte[0][4:0], 2)) else $error("bank wrong");
  a_multi_field: assert property (ce && tel_valid && mode == 2'h2 ##1 ce |=> // RULE8
    dec_out.field_sel == $past(tel_byte[2][4:0], 2)) else $error("field wrong");
  a_hold_idle: assert property (!ce |=> $stable(dec_out)) else $error("changed while frozen");

  // ------------------------------------------------------------
  // Checks on fields of other modes and on the safe state
  // ------------------------------------------------------------
  // A field that leaks from another mode would steer the wrong function
  a_two_func_rest: assert property (ce && tel_valid && mode == 2'h0 ##1 ce |=> // RULE1 RULE2
    dec_out.sel_joint_lo == 5'h00 && dec_out.sel_joint_hi == 5'h00 &&
    dec_out.bank_sel == 5'h00 && dec_out.field_sel == 5'h00)
    else $error("two-function side fields not zero");
  a_four_rest: assert property (ce && tel_valid && mode == 2'h1 ##1 ce |=> // RULE5 RULE6
    dec_out.sel_a == 5'h00 && dec_out.sel_b == 5'h00 &&
    dec_out.bank_sel == 5'h00 && dec_out.field_sel == 5'h00)
    else $error("four-field side fields not zero");
  a_multi_rest: assert property (ce && tel_valid && mode == 2'h2 ##1 ce |=> // RULE7 RULE8
    dec_out.sel_a == 5'h00 && dec_out.sel_b == 5'h00 &&
    dec_out.sel_joint_lo == 5'h00 && dec_out.sel_joint_hi == 5'h00)
    else $error("multi-config side fields not zero");
  a_raw_first: assert property (ce && tel_valid ##1 ce |=> // RULE1 RULE5 RULE7
    switch_input_first_to_fifth == $past(tel_byte[0][4:0], 2))
    else $error("raw first group wrong");
  a_raw_sixth: assert property (ce && tel_valid ##1 ce |=> // RULE2 RULE6 RULE8
    switch_input_sixth_to_tenth == $past(tel_byte[2][4:0], 2))
    else $error("raw second group wrong");
  a_bad_safe: assert property (ce && tel_valid && mode == 2'h3 ##1 ce |=> // RULE3 RULE4
    dec_out == '0 && mode_err)
    else $error("invalid mode not safe");
  a_good_no_err: assert property (ce && tel_valid && mode != 2'h3 ##1 ce |=>
    !mode_err) else $error("error flag on a valid mode");
  a_no_take_hold: assert property (ce && !tel_valid |=> ##1
    ($stable(dec_out) && $stable(mode_err) && $stable(switch_input_first_to_fifth)))
    else $error("outputs changed without a telegram");
  a_hold_raw: assert property (!ce |=>
    $stable(switch_input_first_to_fifth) && $stable(switch_input_sixth_to_tenth) &&
    $stable(mode_err)) else $error("raw outputs changed while frozen");

  c_two_func: cover property (tel_valid && mode == 2'h0 ##2 dec_out.sel_a != 5'h0);
  c_four: cover property (tel_valid && mode == 2'h1 ##2 dec_out.sel_joint_hi != 5'h0);
  c_multi: cover property (tel_valid && mode == 2'h2 ##2 dec_out.bank_sel != 5'h0);
  c_bad: cover property (mode_err);
  c_frozen: cover property (!ce && tel_valid);
endmodule // sotd_decoder

//--- sim/sotd_host_model.sv
// Host model that sends safe output telegrams
`timescale 1ns/1ps
module sotd_host_model (
  input wire logic clk,
  output logic [1:0] mode,
  output logic tel_valid,
  output logic [7:0] tel_byte [6]
);
  initial begin
    tel_valid = 1'b0;
    mode = 2'h3;
    for (int i = 0; i < 6; i++) tel_byte[i] = 8'hff;
  end
  // One telegram for one cycle; dirty sets reserved bits to prove they are ignored
  task automatic send(input logic [1:0] m, input logic [4:0] lo, input logic [4:0] hi,
      input logic [1:0] ra, input logic [1:0] rb, input logic dirty);
    logic [7:0] rsv;
    rsv = dirty ? 8'hff : 8'h00;
    @(negedge clk);
    mode = m;
    tel_byte[0] = {rsv[2:0], lo};
    tel_byte[1] = rsv;
    tel_byte[2] = {rsv[2:0], hi};
    tel_byte[3] = rsv;
    tel_byte[4] = {rsv[5:0], ra};
    tel_byte[5] = {rsv[5:0], rb};
    tel_valid = 1'b1;
    @(negedge clk);
    tel_valid = 1'b0;
    // Stale bytes are inverted so a late sample cannot match by luck
    for (int i = 0; i < 6; i++) tel_byte[i] = ~tel_byte[i];
    mode = ~m;
  endtask
endmodule // sotd_host_model

//--- sim/safe_output_telegram_decoder_tb.sv
// Testbench for the safe output telegram decoder
`timescale 1ns/1ps
module safe_output_telegram_decoder_tb import sotd_pkg::*; ;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic [1:0] mode;
  logic tel_valid;
  logic [7:0] tel_byte [6];
  logic [4:0] sw_lo;
  logic [4:0] sw_hi;
  sotd_out_type dec_out;
  logic mode_err;
  int err_total = 0;
  int checked = 0;
  always #4 clk = ~clk;
  sotd_host_model i_host (.clk(clk), .mode(mode), .tel_valid(tel_valid), .tel_byte(tel_byte));
  sotd_decoder i_dut (.clk(clk), .nrst(nrst), .ce(ce), .mode(mode), .tel_valid(tel_valid),
    .tel_byte(tel_byte), .switch_input_first_to_fifth(sw_lo),
    .switch_input_sixth_to_tenth(sw_hi), .dec_out(dec_out), .mode_err(mode_err));
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Outputs settle one edge after the take edge
  task automatic go(input logic [1:0] m, input logic [4:0] lo, input logic [4:0] hi,
      input logic [1:0] ra, input logic [1:0] rb, input logic dirty, input sotd_out_type e);
    i_host.send(m, lo, hi, ra, rb, dirty);
    repeat (2) @(negedge clk);
    check(dec_out, e);
    check(34'(sw_lo), 34'(lo));
    check(34'(sw_hi), 34'(hi));
    check(34'(mode_err), 34'(m == 2'h3));
  endtask
  task automatic t_two();
    sotd_out_type e;
    e = '0;
    e.sel_a = 5'h15;
    e.sel_b = 5'h0a;
    e.res_a = 2'b10;
    e.res_b = 2'b01;
    go(2'h0, 5'h15, 5'h0a, 2'b01, 2'b10, 1'b0, e);
  endtask
  task automatic t_four();
    sotd_out_type e;
    e = '0;
    e.sel_joint_lo = 5'h1f;
    e.sel_joint_hi = 5'h01;
    e.res_a = 2'b11;
    go(2'h1, 5'h1f, 5'h01, 2'b11, 2'b00, 1'b0, e);
  endtask
  task automatic t_multi();
    sotd_out_type e;
    e = '0;
    e.bank_sel = 5'h01;
    e.field_sel = 5'h10;
    e.res_b = 2'b11;
    go(2'h2, 5'h01, 5'h10, 2'b00, 2'b11, 1'b0, e);
  endtask
  // Reserved bits all set must leave the decoded values untouched
  task automatic t_rsvd();
    sotd_out_type e;
    e = '0;
    e.sel_a = 5'h0a;
    e.sel_b = 5'h15;
    go(2'h0, 5'h0a, 5'h15, 2'b00, 2'b00, 1'b1, e);
  endtask
  task automatic t_bad();
    go(2'h3, 5'h1f, 5'h1f, 2'b11, 2'b11, 1'b0, '0);
  endtask
  // A telegram sent while the clock enable is low must leave every output as it was
  task automatic t_freeze();
    @(negedge clk);
    ce = 1'b0;
    i_host.send(2'h0, 5'h03, 5'h0c, 2'b11, 2'b11, 1'b0);
    repeat (2) @(negedge clk);
    check(dec_out, '0);
    check(34'(sw_lo), 34'(5'h1f));
    check(34'(mode_err), 34'(1'b1));
    ce = 1'b1;
    repeat (2) @(negedge clk);
    check(dec_out, '0);
    check(34'(sw_hi), 34'(5'h1f));
  endtask
  // Reset in mid-run clears every output; the first telegram after it decodes normally
  task automatic t_reset();
    sotd_out_type e;
    e = '0;
    e.sel_joint_lo = 5'h0c;
    e.sel_joint_hi = 5'h13;
    e.res_a = 2'b01;
    e.res_b = 2'b10;
    @(negedge clk);
    nrst = 1'b0;
    @(negedge clk);
    check(dec_out, '0);
    check(34'(sw_lo), 34'(5'h00));
    check(34'(mode_err), 34'(1'b0));
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    check(34'(sw_hi), 34'(5'h00));
    check(dec_out, '0);
    go(2'h1, 5'h0c, 5'h13, 2'b10, 2'b01, 1'b1, e);
  endtask
  task automatic give_verdict();
    if (err_total == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    t_two();
    t_four();
    t_multi();
    t_rsvd();
    t_bad();
    t_freeze();
    t_reset();
    give_verdict();
  end
  // About forty-five cycles are needed; this leaves ample margin
  initial begin
    #4000;
    err_total++;
    give_verdict();
  end
endmodule // safe_output_telegram_decoder_tb
